/* core/nccsb_pkg.sv */
/*
 Constants, types and state layout of the network command/status bank.
 Assumes one clock (mclk, 50 MHz) and a synchronous active-low reset.
*/
// Summary of operation
// - Control word written only from fieldbus port
// - Control word commands act only when fieldbus controls device
// - Bit 0 starts or stops the motor
// - Bit 1 enable, bit 4 remote, bits 5, 6 and 8-15 reserved
// - Bit 2 enables inching
// - Bit 3 selects reverse direction
// - Bit 7 resets fault only while faulted
// - Status bits 0-2: start-up, wait, test
// - Status bits 3-5: card, panel, firmware copy
// - Status bits 6-8: reset, type change, incompatible
// - Command bit 0 aborts guided start-up
// - Command bit 2 aborts test mode
// - Command bit 7 aborts control-type change
// - Output word refuses operator panel writes
// - Output follows word only when selected
// - Output bits 0-2 drive three relays
// - Control word is zero after reset
`default_nettype none

package nccsb_pkg;

	// ==========================================
	// Word selection and access sources
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_STAT = 2'h1;
	localparam logic [1:0] SEL_CMD = 2'h2;
	localparam logic [1:0] SEL_DOUT = 2'h3;

	typedef enum logic [1:0] {
		SRC_FIELDBUS = 2'b00,
		SRC_SERIAL = 2'b01,
		SRC_PANEL = 2'b10,
		SRC_USB = 2'b11
	} nccsb_src_e;

	// ==========================================
	// Field layout
	localparam logic [15:0] CTRL_MASK = 16'h009F;
	localparam logic [15:0] STAT_MASK = 16'h01FF;
	localparam logic [15:0] CMD_MASK = 16'h0085;
	localparam logic [15:0] DOUT_MASK = 16'h0007;
	localparam int B_START = 0;
	localparam int B_ENABLE = 1;
	localparam int B_JOG = 2;
	localparam int B_DIR = 3;
	localparam int B_REMOTE = 4;
	localparam int B_FRESET = 7;
	localparam int C_ABORT_SU = 0;
	localparam int C_ABORT_TM = 2;
	localparam int C_ABORT_CT = 7;
	localparam int N_RELAY = 3;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic req;
		logic wr;
		nccsb_src_e src;
		logic [1:0] sel;
		logic [15:0] wdata;
	} nccsb_req_s;

	typedef struct packed {
		logic ack;
		logic err;
		logic [15:0] rdata;
	} nccsb_rsp_s;

	typedef struct packed {
		logic run;
		logic enable;
		logic inching_enable;
		logic direction_select;
		logic local_remote_select;
		logic fault_reset;
		logic abort_startup;
		logic abort_test;
		logic abort_ctrl;
	} nccsb_act_s;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] cmd;
		logic [15:0] dout;
		nccsb_rsp_s rsp;
		nccsb_act_s act;
		logic [N_RELAY-1:0] relay;
	} nccsb_state_s;

	localparam nccsb_state_s ST_RESET = '0;

endpackage : nccsb_pkg

`default_nettype wire

/* core/nccsb_bank.sv */
/*
 Command/status word bank facing the fieldbus module and other access paths.
 Assumes the caller presents one request at a time, synchronous to mclk,
 tagged with the access source; status and selections come from the device.
*/
`timescale 1ns/1ps
`default_nettype none

module nccsb_bank (
	input wire logic mclk, // 50 MHz clock
	input wire logic rstn, // Sync reset, low
	input wire nccsb_pkg::nccsb_req_s acc, // Word access request
	input wire logic fieldbus_in_control, // Source selection names fieldbus
	input wire logic fault_active, // Device in fault
	input wire logic [8:0] cfg_status, // Configuration-mode conditions
	input wire logic [2:0] output_from_word, // Relay function selects word
	input wire logic [2:0] output_other_value, // Relay value from other function
	output logic acc_ack, // Answer strobe
	output logic acc_err, // Write refused
	output logic [15:0] acc_rdata, // Read data
	output nccsb_pkg::nccsb_act_s act, // Executed commands
	output logic [2:0] relay_outputs // Closed when 1
);

	// ==========================================
	// State
	nccsb_pkg::nccsb_state_s s_q;
	nccsb_pkg::nccsb_state_s s_d;
	logic wr_ok;
	logic [15:0] wmask;
	logic [15:0] stat_word;

	assign stat_word = {7'h00, cfg_status} & nccsb_pkg::STAT_MASK;

	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rsp.ack = 1'b0;
		s_d.rsp.err = 1'b0;
		s_d.act.abort_startup = 1'b0;
		s_d.act.abort_test = 1'b0;
		s_d.act.abort_ctrl = 1'b0;
		wr_ok = 1'b0;
		wmask = 16'h0000;

		// Address decoding and access rights
		if (acc.sel == nccsb_pkg::SEL_CTRL) begin
			wr_ok = (acc.src == nccsb_pkg::SRC_FIELDBUS);
			wmask = nccsb_pkg::CTRL_MASK;
		end else if (acc.sel == nccsb_pkg::SEL_STAT) begin
			wr_ok = 1'b0;
		end else if (acc.sel == nccsb_pkg::SEL_CMD) begin
			wr_ok = (acc.src != nccsb_pkg::SRC_PANEL);
			wmask = nccsb_pkg::CMD_MASK;
		end else begin
			wr_ok = (acc.src != nccsb_pkg::SRC_PANEL);
			wmask = nccsb_pkg::DOUT_MASK;
		end

		if (acc.req) begin
			s_d.rsp.ack = 1'b1;
			s_d.rsp.err = acc.wr & ~wr_ok;
			if (acc.sel == nccsb_pkg::SEL_CTRL) begin
				s_d.rsp.rdata = s_q.ctrl;
			end else if (acc.sel == nccsb_pkg::SEL_STAT) begin
				s_d.rsp.rdata = stat_word;
			end else if (acc.sel == nccsb_pkg::SEL_CMD) begin
				s_d.rsp.rdata = s_q.cmd;
			end else begin
				s_d.rsp.rdata = s_q.dout;
			end
		end

		// Reserved bits dropped at the write, so they read back as zero
		if (acc.req && acc.wr && wr_ok) begin
			if (acc.sel == nccsb_pkg::SEL_CTRL) begin
				s_d.ctrl = acc.wdata & wmask;
			end else if (acc.sel == nccsb_pkg::SEL_CMD) begin
				s_d.cmd = acc.wdata & wmask;
				s_d.act.abort_startup = acc.wdata[nccsb_pkg::C_ABORT_SU];
				s_d.act.abort_test = acc.wdata[nccsb_pkg::C_ABORT_TM];
				s_d.act.abort_ctrl = acc.wdata[nccsb_pkg::C_ABORT_CT];
			end else if (acc.sel == nccsb_pkg::SEL_DOUT) begin
				s_d.dout = acc.wdata & wmask;
			end
		end

		// Commands gated by source selection; otherwise all drop to the safe zero
		s_d.act.run = fieldbus_in_control & s_q.ctrl[nccsb_pkg::B_START];
		s_d.act.enable = fieldbus_in_control & s_q.ctrl[nccsb_pkg::B_ENABLE];
		s_d.act.inching_enable = fieldbus_in_control & s_q.ctrl[nccsb_pkg::B_JOG];
		s_d.act.direction_select = fieldbus_in_control & s_q.ctrl[nccsb_pkg::B_DIR];
		s_d.act.local_remote_select = fieldbus_in_control
			& s_q.ctrl[nccsb_pkg::B_REMOTE];
		s_d.act.fault_reset = fieldbus_in_control & fault_active
			& s_q.ctrl[nccsb_pkg::B_FRESET];

		for (int i = 0; i < nccsb_pkg::N_RELAY; i++) begin
			s_d.relay[i] = output_from_word[i] ? s_q.dout[i] : output_other_value[i];
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s_q <= nccsb_pkg::ST_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign acc_ack = s_q.rsp.ack;
	assign acc_err = s_q.rsp.err;
	assign acc_rdata = s_q.rsp.rdata;
	assign act = s_q.act;
	assign relay_outputs = s_q.relay;

	// ==========================================
	// Assertion helpers
	// Accepted writes, restated from the access rights instead of the decoder
	logic ctrl_wr_ok;
	logic cmd_wr_ok;
	logic dout_wr_ok;

	assign ctrl_wr_ok = acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CTRL
		&& acc.src == nccsb_pkg::SRC_FIELDBUS;
	assign cmd_wr_ok = acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CMD
		&& acc.src != nccsb_pkg::SRC_PANEL;
	assign dout_wr_ok = acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_DOUT
		&& acc.src != nccsb_pkg::SRC_PANEL;

	// ==========================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_fb_ctrl_wr;
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CTRL
			&& acc.src == nccsb_pkg::SRC_FIELDBUS;
	endsequence

	sequence s_bad_ctrl_wr;
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CTRL
			&& acc.src != nccsb_pkg::SRC_FIELDBUS;
	endsequence

	a_ctrl_wr_refused: assert property (
		s_bad_ctrl_wr |=> acc_err && $stable(s_q.ctrl))
		else $error("control word changed from non-fieldbus source");

	a_ctrl_wr_accept: assert property (
		s_fb_ctrl_wr |=> !acc_err
			&& s_q.ctrl == ($past(acc.wdata) & nccsb_pkg::CTRL_MASK))
		else $error("fieldbus control write not stored");

	a_cmd_gated: assert property (
		!fieldbus_in_control |=> !act.run && !act.enable && !act.fault_reset)
		else $error("command executed without fieldbus control");

	a_run_follows: assert property (
		s_fb_ctrl_wr ##1 fieldbus_in_control |=>
			act.run == $past(s_q.ctrl[nccsb_pkg::B_START], 1))
		else $error("run does not follow start bit");

	a_mode_bits: assert property (
		fieldbus_in_control |=> act.enable == $past(s_q.ctrl[nccsb_pkg::B_ENABLE])
			&& act.local_remote_select == $past(s_q.ctrl[nccsb_pkg::B_REMOTE]))
		else $error("enable or remote bit not executed");

	a_inch_dir: assert property (
		fieldbus_in_control |=> act.inching_enable == $past(s_q.ctrl[nccsb_pkg::B_JOG])
			&& act.direction_select == $past(s_q.ctrl[nccsb_pkg::B_DIR]))
		else $error("inching or direction bit not executed");

	a_fault_reset: assert property (
		act.fault_reset |-> $past(fault_active) && $past(s_q.ctrl[nccsb_pkg::B_FRESET]))
		else $error("fault reset without fault or bit");

	a_status_read: assert property (
		acc.req && !acc.wr && acc.sel == nccsb_pkg::SEL_STAT |=>
			acc_ack && acc_rdata == {7'h00, $past(cfg_status)})
		else $error("status word read wrong");

	a_status_ro: assert property (
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_STAT |=> acc_ack && acc_err)
		else $error("status word accepted a write");

	a_abort_pulse: assert property (
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CMD
			&& acc.src != nccsb_pkg::SRC_PANEL |=>
			act.abort_startup == $past(acc.wdata[nccsb_pkg::C_ABORT_SU])
			&& act.abort_test == $past(acc.wdata[nccsb_pkg::C_ABORT_TM])
			&& act.abort_ctrl == $past(acc.wdata[nccsb_pkg::C_ABORT_CT]))
		else $error("abort pulse missing");

	a_abort_single: assert property (
		act.abort_test && !(cmd_wr_ok && acc.wdata[nccsb_pkg::C_ABORT_TM])
			|=> !act.abort_test)
		else $error("abort pulse longer than one cycle");

	a_dout_panel: assert property (
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_DOUT
			&& acc.src == nccsb_pkg::SRC_PANEL |=> acc_err && $stable(s_q.dout))
		else $error("panel wrote output word");

	a_relay_follow: assert property (
		output_from_word[0] |=> relay_outputs[0] == $past(s_q.dout[0]))
		else $error("relay one ignores word");

	a_relay_other: assert property (
		!output_from_word[2] |=> relay_outputs[2] == $past(output_other_value[2]))
		else $error("relay three ignores its function");

	a_reset_zero: assert property (@(posedge mclk) disable iff (1'b0)
		!rstn |=> s_q.ctrl == 16'h0000 && act == '0)
		else $error("control word not zero after reset");

	a_reserved_zero: assert property (
		(s_q.ctrl & ~nccsb_pkg::CTRL_MASK) == 16'h0000
			&& (s_q.cmd & ~nccsb_pkg::CMD_MASK) == 16'h0000
			&& (s_q.dout & ~nccsb_pkg::DOUT_MASK) == 16'h0000)
		else $error("reserved bits hold data");

	// ==========================================
	// Access answers
	a_ack_answer: assert property (
		acc.req |=> acc_ack)
		else $error("access not answered");

	a_ack_idle: assert property (
		!acc.req |=> !acc_ack && !acc_err)
		else $error("answer without request");

	a_err_with_ack: assert property (
		acc_err |-> acc_ack)
		else $error("refusal outside an answer");

	a_read_no_err: assert property (
		acc.req && !acc.wr |=> !acc_err)
		else $error("read refused");

	a_ctrl_readback: assert property (
		acc.req && !acc.wr && acc.sel == nccsb_pkg::SEL_CTRL |=>
			acc_rdata == $past(s_q.ctrl))
		else $error("control word read wrong");

	a_cmd_readback: assert property (
		acc.req && !acc.wr && acc.sel == nccsb_pkg::SEL_CMD |=>
			acc_rdata == $past(s_q.cmd))
		else $error("command word read wrong");

	a_dout_readback: assert property (
		acc.req && !acc.wr && acc.sel == nccsb_pkg::SEL_DOUT |=>
			acc_rdata == $past(s_q.dout))
		else $error("output word read wrong");

	a_rdata_hold: assert property (
		!acc.req |=> $stable(acc_rdata))
		else $error("read data moved without an access");

	// ==========================================
	// Control word and executed commands
	a_ctrl_hold: assert property (
		!ctrl_wr_ok |=> $stable(s_q.ctrl))
		else $error("control word changed without a fieldbus write");

	a_ctrl_other_read: assert property (
		acc.req && !acc.wr && acc.sel == nccsb_pkg::SEL_CTRL
			&& acc.src != nccsb_pkg::SRC_FIELDBUS |=> acc_ack && !acc_err)
		else $error("control word not readable from other sources");

	a_stop_bit: assert property (
		!s_q.ctrl[nccsb_pkg::B_START] |=> !act.run)
		else $error("motor runs with start bit clear");

	a_gated_modes: assert property (
		!fieldbus_in_control |=> !act.inching_enable && !act.direction_select
			&& !act.local_remote_select)
		else $error("mode bits executed without fieldbus control");

	a_fault_idle: assert property (
		!fault_active |=> !act.fault_reset)
		else $error("fault reset outside a fault");

	a_fault_follow: assert property (
		fieldbus_in_control && fault_active |=>
			act.fault_reset == $past(s_q.ctrl[nccsb_pkg::B_FRESET]))
		else $error("fault reset bit not executed");

	// ==========================================
	// Command word
	a_cmd_store: assert property (
		cmd_wr_ok |=> !acc_err && s_q.cmd == ($past(acc.wdata) & nccsb_pkg::CMD_MASK))
		else $error("command word not stored");

	a_cmd_panel: assert property (
		acc.req && acc.wr && acc.sel == nccsb_pkg::SEL_CMD
			&& acc.src == nccsb_pkg::SRC_PANEL |=> acc_err && $stable(s_q.cmd)
			&& !act.abort_startup && !act.abort_test && !act.abort_ctrl)
		else $error("panel write reached the command word");

	a_cmd_hold: assert property (
		!cmd_wr_ok |=> $stable(s_q.cmd))
		else $error("command word changed without a write");

	a_abort_su_cause: assert property (
		!(cmd_wr_ok && acc.wdata[nccsb_pkg::C_ABORT_SU]) |=> !act.abort_startup)
		else $error("start-up abort without a command");

	a_abort_tm_cause: assert property (
		!(cmd_wr_ok && acc.wdata[nccsb_pkg::C_ABORT_TM]) |=> !act.abort_test)
		else $error("test abort without a command");

	a_abort_ct_cause: assert property (
		!(cmd_wr_ok && acc.wdata[nccsb_pkg::C_ABORT_CT]) |=> !act.abort_ctrl)
		else $error("control-type abort without a command");

	// ==========================================
	// Output word and relays
	a_dout_store: assert property (
		dout_wr_ok |=> !acc_err && s_q.dout == ($past(acc.wdata) & nccsb_pkg::DOUT_MASK))
		else $error("output word not stored");

	a_dout_hold: assert property (
		!dout_wr_ok |=> $stable(s_q.dout))
		else $error("output word changed without a write");

	a_relay_two: assert property (
		output_from_word[1] |=> relay_outputs[1] == $past(s_q.dout[1]))
		else $error("relay two ignores word");

	a_relay_three: assert property (
		output_from_word[2] |=> relay_outputs[2] == $past(s_q.dout[2]))
		else $error("relay three ignores word");

	a_relay_one_other: assert property (
		!output_from_word[0] |=> relay_outputs[0] == $past(output_other_value[0]))
		else $error("relay one ignores its function");

	// ==========================================
	// Reset
	a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0)
		!rstn |=> !acc_ack && !acc_err && acc_rdata == 16'h0000 && relay_outputs == 3'h0)
		else $error("outputs not quiet after reset");

	a_reset_words: assert property (@(posedge mclk) disable iff (1'b0)
		!rstn |=> s_q.cmd == 16'h0000 && s_q.dout == 16'h0000)
		else $error("words not zero after reset");

endmodule : nccsb_bank

`default_nettype wire

/* tb/nccsb_master.sv */
/*
 Access master for the word bank, driving any of the four access sources.
 Assumes a one-cycle request pulse, answered one cycle after it is taken.
*/
`timescale 1ns/1ps
`default_nettype none

module nccsb_master (
	input wire logic mclk, // Clock
	output var nccsb_pkg::nccsb_req_s acc, // Request to bank
	input wire logic ack, // Answer strobe
	input wire logic err, // Refusal flag
	input wire logic [15:0] rdata // Read data
);
	initial acc = '0;

	// ==========================================
	// One access
	// Released wr, sel and wdata show inverted values so nothing stale looks valid
	task automatic xfer(input logic wr, input nccsb_pkg::nccsb_src_e src,
		input logic [1:0] sel, input logic [15:0] wd,
		output logic e, output logic [15:0] rd, output logic to);
		to = 1'h1;
		@(posedge mclk);
		acc <= '{req: 1'h1, wr: wr, src: src, sel: sel, wdata: wd};
		@(posedge mclk);
		acc <= '{req: 1'h0, wr: ~wr, src: src, sel: ~sel, wdata: ~wd};
		for (int i = 0; i < 4 && to; i++) begin
			@(posedge mclk);
			if (ack === 1'h1) begin
				e = err;
				rd = rdata;
				to = 1'h0;
			end
		end
	endtask : xfer
endmodule : nccsb_master

`default_nettype wire

/* tb/tb_top.sv */
/*
 Self-checking bench for the command/status word bank.
 Assumes the bank answers each access one cycle after it is taken.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; \
	$display("CHECK FAILED at %0t: got %h want %h", $time, g, x); end end

module tb_top;
	logic mclk, rstn, fic, fault, ack, err, e, to;
	logic [8:0] cfs;
	logic [2:0] ofw, oov, relays;
	logic [15:0] rdata, rd;
	nccsb_pkg::nccsb_req_s acc;
	nccsb_pkg::nccsb_act_s act;
	int miscompares, checked;
	int aborts [3];

	nccsb_bank dut (.mclk(mclk), .rstn(rstn), .acc(acc), .fieldbus_in_control(fic),
		.fault_active(fault), .cfg_status(cfs), .output_from_word(ofw),
		.output_other_value(oov), .acc_ack(ack), .acc_err(err), .acc_rdata(rdata),
		.act(act), .relay_outputs(relays));
	nccsb_master m (.mclk(mclk), .acc(acc), .ack(ack), .err(err), .rdata(rdata));

	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end

	// Counting cycles, not edges, also catches a pulse that stands too long
	always @(posedge mclk) begin
		if (act.abort_startup === 1'h1) aborts[0]++;
		if (act.abort_test === 1'h1) aborts[1]++;
		if (act.abort_ctrl === 1'h1) aborts[2]++;
	end

	// ==========================================
	// Tasks
	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic acc_do(input logic wr, input int src, input logic [1:0] sel,
		input logic [15:0] wd, input logic xe, input logic [15:0] xr);
		m.xfer(wr, nccsb_pkg::nccsb_src_e'(src), sel, wd, e, rd, to);
		if (to) begin
			miscompares++;
			report_and_stop();
		end
		`CHK(e, xe)
		if (!wr) `CHK(rd, xr)
	endtask : acc_do

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_n

	// ==========================================
	// Sequence
	initial begin
		rstn = 1'h0;
		fic = 1'h1;
		fault = 1'h0;
		cfs = 9'h000;
		ofw = 3'h7;
		oov = 3'h0;
		miscompares = 0;
		checked = 0;
		aborts = '{0, 0, 0};
		wait_n(5);
		rstn <= 1'h1;
		acc_do(1'h0, 0, nccsb_pkg::SEL_CTRL, 16'h0000, 1'h0, 16'h0000);
		acc_do(1'h0, 0, nccsb_pkg::SEL_DOUT, 16'h0000, 1'h0, 16'h0000);
		`CHK(act, 9'h000)
		acc_do(1'h1, 0, nccsb_pkg::SEL_CTRL, 16'hFFFF, 1'h0, 16'h0000);
		acc_do(1'h0, 1, nccsb_pkg::SEL_CTRL, 16'h0000, 1'h0, 16'h009F);
		wait_n(2);
		`CHK(act, 9'h1F0)
		fault <= 1'h1;
		wait_n(3);
		`CHK(act.fault_reset, 1'h1)
		fic <= 1'h0;
		wait_n(3);
		`CHK(act, 9'h000)
		fic <= 1'h1;
		fault <= 1'h0;
		for (int s = 1; s < 4; s++)
			acc_do(1'h1, s, nccsb_pkg::SEL_CTRL, 16'h0000, 1'h1, 16'h0000);
		acc_do(1'h0, 3, nccsb_pkg::SEL_CTRL, 16'h0000, 1'h0, 16'h009F);
		acc_do(1'h1, 0, nccsb_pkg::SEL_CTRL, 16'h0009, 1'h0, 16'h0000);
		wait_n(2);
		`CHK(act, 9'h120)
		for (int i = 0; i < 2; i++) begin
			cfs <= i ? 9'h0AA : 9'h155;
			wait_n(1);
			acc_do(1'h0, 2, nccsb_pkg::SEL_STAT, 16'h0000, 1'h0, i ? 16'h00AA : 16'h0155);
		end
		acc_do(1'h1, 0, nccsb_pkg::SEL_STAT, 16'hFFFF, 1'h1, 16'h0000);
		acc_do(1'h1, 0, nccsb_pkg::SEL_CMD, 16'hFFFF, 1'h0, 16'h0000);
		acc_do(1'h0, 1, nccsb_pkg::SEL_CMD, 16'h0000, 1'h0, 16'h0085);
		acc_do(1'h1, 1, nccsb_pkg::SEL_CMD, 16'h0000, 1'h0, 16'h0000);
		acc_do(1'h1, 2, nccsb_pkg::SEL_CMD, 16'h0085, 1'h1, 16'h0000);
		wait_n(2);
		`CHK(aborts[0], 1)
		`CHK(aborts[1], 1)
		`CHK(aborts[2], 1)
		acc_do(1'h1, 1, nccsb_pkg::SEL_DOUT, 16'hFFFF, 1'h0, 16'h0000);
		acc_do(1'h0, 3, nccsb_pkg::SEL_DOUT, 16'h0000, 1'h0, 16'h0007);
		`CHK(relays, 3'h7)
		acc_do(1'h1, 2, nccsb_pkg::SEL_DOUT, 16'h0000, 1'h1, 16'h0000);
		wait_n(2);
		`CHK(relays, 3'h7)
		acc_do(1'h1, 3, nccsb_pkg::SEL_DOUT, 16'h0002, 1'h0, 16'h0000);
		wait_n(2);
		`CHK(relays, 3'h2)
		ofw <= 3'h6;
		oov <= 3'h1;
		wait_n(3);
		`CHK(relays, 3'h3)
		rstn <= 1'h0;
		wait_n(2);
		rstn <= 1'h1;
		acc_do(1'h0, 0, nccsb_pkg::SEL_CTRL, 16'h0000, 1'h0, 16'h0000);
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
